//--- pkg/flash_ctl_regs.svh
// register offsets, command codes, status bit positions and timing counts
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// controller register offsets (byte addresses)
`define REG_CMD          8'h00
`define REG_ADDR         8'h04
`define REG_DATA         8'h08
`define REG_STATUS       8'h0C
`define REG_RESULT       8'h10

// command register op field
`define OP_BLOCK_ERASE   4'h1
`define OP_CHIP_ERASE    4'h2
`define OP_BYTE_WRITE    4'h3
`define OP_SUSPEND       4'h4
`define OP_RESUME        4'h5
`define OP_LOCK_BLOCK    4'h6
`define OP_LOCK_PERM     4'h7
`define OP_CLEAR_LOCKS   4'h8
`define OP_READ_ARRAY    4'h9
`define OP_CLEAR_STATUS  4'hA
`define OP_READ_ID       4'hB
`define OP_READ_STATUS   4'hC
`define OP_READ          4'hD

// flash command codes
`define FC_ERASE_SETUP   8'h20
`define FC_CHIP_SETUP    8'h30
`define FC_WRITE_SETUP   8'h40
`define FC_WRITE_SETUP2  8'h10
`define FC_CONFIRM       8'hD0
`define FC_SUSPEND       8'hB0
`define FC_LOCK_SETUP    8'h60
`define FC_LOCK_BLOCK    8'h01
`define FC_LOCK_PERM     8'hF1
`define FC_READ_ARRAY    8'hFF
`define FC_READ_STATUS   8'h70
`define FC_CLEAR_STATUS  8'h50
`define FC_READ_ID       8'h90

// status bit positions
`define SB_READY         7
`define SB_ERASE_SUSP    6
`define SB_ERASE_ERR     5
`define SB_WRITE_ERR     4
`define SB_SUPPLY_LOW    3
`define SB_WRITE_SUSP    2
`define SB_PROTECT       1
`define SB_RESERVED_MASK 8'hFE

// bus cycle timing on the flash pins
`define CYCLE_NS         100
`define CLK_NS           5
`define CYCLE_CLKS       ((`CYCLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- pkg/flash_ctl_pkg.sv
// types shared by the flash controller
package flash_ctl_pkg;
    typedef struct packed {
        logic        we_n;
        logic        oe_n;
        logic        ce_n;
        logic [19:0] addr;
    } flash_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } cycle_req_t;
endpackage

//--- design/flash_bus_cycle.sv
// one timed write or read cycle on the flash pins
`include "flash_ctl_regs.svh"
module flash_bus_cycle
    import flash_ctl_pkg::*;
#(
    parameter int CYCLE = `CYCLE_CLKS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request
    input  wire logic        start,
    input  wire cycle_req_t  req,
    input  wire logic [19:0] addr,
    output logic             busy,
    output logic             done,
    output logic [7:0]       rdata,
    // pins
    output flash_ctrl_t      pins,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_i
);
    logic [7:0]  cnt_r,   cnt_nxt;
    logic        act_r,   act_nxt;
    logic        done_r,  done_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    flash_ctrl_t pins_r,  pins_nxt;
    logic [7:0]  dq_r,    dq_nxt;
    logic        oe_r,    oe_nxt;

    always_comb begin
        cnt_nxt   = cnt_r;
        act_nxt   = act_r;
        done_nxt  = 1'b0;
        rdata_nxt = rdata_r;
        pins_nxt  = pins_r;
        dq_nxt    = dq_r;
        oe_nxt    = oe_r;
        if (!act_r && start) begin
            act_nxt       = 1'b1;
            cnt_nxt       = 8'(CYCLE);
            pins_nxt.addr = addr;
            pins_nxt.ce_n = 1'b0;
            pins_nxt.we_n = ~req.wr;
            pins_nxt.oe_n = req.wr;
            dq_nxt        = req.data;
            oe_nxt        = req.wr;
        end else if (act_r) begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
                rdata_nxt = pins_r.oe_n ? rdata_r : dq_i;
                pins_nxt  = '{we_n: 1'b1, oe_n: 1'b1, ce_n: 1'b1, addr: pins_r.addr};
                oe_nxt    = 1'b0;
                act_nxt   = 1'b0;
                done_nxt  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r   <= 8'h00;
            act_r   <= 1'b0;
            done_r  <= 1'b0;
            rdata_r <= 8'h00;
            pins_r  <= '{we_n: 1'b1, oe_n: 1'b1, ce_n: 1'b1, addr: 20'h0_0000};
            dq_r    <= 8'h00;
            oe_r    <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            act_r   <= act_nxt;
            done_r  <= done_nxt;
            rdata_r <= rdata_nxt;
            pins_r  <= pins_nxt;
            dq_r    <= dq_nxt;
            oe_r    <= oe_nxt;
        end
    end

    assign busy  = act_r;
    assign done  = done_r;
    assign rdata = rdata_r;
    assign pins  = pins_r;
    assign dq_o  = dq_r;
    assign dq_oe = oe_r;
endmodule

//--- design/flash_ctl.sv
// host-side controller issuing command sequences to a byte-wide flash
// Functional notes
// - host masks reserved bit 0 when polling status
// - block erase: 20H anywhere, D0H in block, then poll
// - chip erase: 30H then D0H; failure on bit 5
// - byte write: 40H or 10H, then data at target
// - B0H suspends erase, D0H resumes; check bit 6 after ready
// - B0H suspends write; on bit 2 may read array, D0H resumes
// - lock: 60H then 01H at block or F1H anywhere
// - clear locks: 60H then D0H; failure on bit 5
// - FFH returns device to read array mode
// - 70H puts device in status read mode
//
// The register offsets and strobed register access are this design's own decisions.
`include "flash_ctl_regs.svh"
module flash_ctl
    import flash_ctl_pkg::*;
#(
    parameter int CYCLE = `CYCLE_CLKS
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // software register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    // flash pins
    output flash_ctrl_t      FLASH_CTRL,
    output logic [7:0]       DQ_O,
    output logic             DQ_OE,
    input  wire logic [7:0]  DQ_I
);
    typedef enum {
        ST_IDLE, ST_FIRST, ST_SECOND, ST_POLL, ST_POLL_WAIT, ST_DONE
    } state_t;

    state_t      st_r,     st_nxt;
    logic [3:0]  op_r,     op_nxt;
    logic [19:0] addr_r,   addr_nxt;
    logic [7:0]  data_r,   data_nxt;
    logic [7:0]  stat_r,   stat_nxt;
    logic [7:0]  result_r, result_nxt;
    logic        err_r,    err_nxt;
    logic [31:0] rdata_r,  rdata_nxt;

    logic        cyc_start;
    cycle_req_t  cyc_req;
    logic [19:0] cyc_addr;
    logic        cyc_busy;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;

    // first code written for each operation other than OP_READ, which starts with a read cycle
    function automatic logic [7:0] first_code(input logic [3:0] op);
        case (op)
            `OP_BLOCK_ERASE:  first_code = `FC_ERASE_SETUP;
            `OP_CHIP_ERASE:   first_code = `FC_CHIP_SETUP;
            `OP_BYTE_WRITE:   first_code = `FC_WRITE_SETUP;
            `OP_SUSPEND:      first_code = `FC_SUSPEND;
            `OP_RESUME:       first_code = `FC_CONFIRM;
            `OP_LOCK_BLOCK,
            `OP_LOCK_PERM,
            `OP_CLEAR_LOCKS:  first_code = `FC_LOCK_SETUP;
            `OP_READ_ARRAY:   first_code = `FC_READ_ARRAY;
            `OP_CLEAR_STATUS: first_code = `FC_CLEAR_STATUS;
            // identifier read
            `OP_READ_ID:      first_code = `FC_READ_ID;
            `OP_READ_STATUS:  first_code = `FC_READ_STATUS;
            default:          first_code = `FC_READ_ARRAY;
        endcase
    endfunction

    // second write of a two-cycle sequence
    function automatic logic [7:0] second_code(input logic [3:0] op, input logic [7:0] d);
        case (op)
            `OP_LOCK_BLOCK:  second_code = `FC_LOCK_BLOCK;
            `OP_LOCK_PERM:   second_code = `FC_LOCK_PERM;
            `OP_BYTE_WRITE:  second_code = d;
            default:         second_code = `FC_CONFIRM;
        endcase
    endfunction

    function automatic logic two_cycle(input logic [3:0] op);
        two_cycle = (op == `OP_BLOCK_ERASE) || (op == `OP_CHIP_ERASE) ||
                    (op == `OP_BYTE_WRITE) || (op == `OP_LOCK_BLOCK) ||
                    (op == `OP_LOCK_PERM) || (op == `OP_CLEAR_LOCKS);
    endfunction

    // operations that end by polling status until ready
    function automatic logic polls(input logic [3:0] op);
        polls = two_cycle(op) || (op == `OP_SUSPEND) || (op == `OP_RESUME);
    endfunction

    always_comb begin
        st_nxt     = st_r;
        op_nxt     = op_r;
        addr_nxt   = addr_r;
        data_nxt   = data_r;
        stat_nxt   = stat_r;
        result_nxt = result_r;
        err_nxt    = err_r;
        rdata_nxt  = 32'h0000_0000;
        cyc_start  = 1'b0;
        cyc_req    = '{wr: 1'b1, data: first_code(op_r)};
        cyc_addr   = addr_r;

        if (WR) begin
            case (ADDR)
                `REG_ADDR: addr_nxt = WDATA[19:0];
                `REG_DATA: data_nxt = WDATA[7:0];
                `REG_CMD: begin
                    if (st_r == ST_IDLE || st_r == ST_DONE) begin
                        op_nxt = WDATA[3:0];
                        st_nxt = ST_FIRST;
                    end else begin
                        err_nxt = 1'b1;
                    end
                end
                `REG_STATUS: if (WDATA[0]) err_nxt = 1'b0;
                default: ;
            endcase
        end

        case (st_r)
            ST_FIRST: begin
                // the done cycle must not relaunch the finished transfer
                cyc_start = ~cyc_busy & ~cyc_done;
                if (op_r == `OP_READ) begin
                    cyc_req = '{wr: 1'b0, data: 8'h00};
                end
                if (cyc_done) begin
                    if (op_r == `OP_READ) begin
                        result_nxt = cyc_rdata;
                        st_nxt     = ST_DONE;
                    end else if (two_cycle(op_r)) begin
                        st_nxt = ST_SECOND;
                    end else if (polls(op_r)) begin
                        st_nxt = ST_POLL;
                    end else begin
                        st_nxt = ST_DONE;
                    end
                end
            end
            ST_SECOND: begin
                cyc_start = ~cyc_busy & ~cyc_done;
                cyc_req   = '{wr: 1'b1, data: second_code(op_r, data_r)};
                if (cyc_done) begin
                    st_nxt = ST_POLL;
                end
            end
            ST_POLL: begin
                cyc_start = ~cyc_busy & ~cyc_done;
                cyc_req   = '{wr: 1'b0, data: 8'h00};
                if (cyc_done) begin
                    stat_nxt = cyc_rdata & `SB_RESERVED_MASK;
                    st_nxt   = cyc_rdata[`SB_READY] ? ST_DONE : ST_POLL_WAIT;
                end
            end
            ST_POLL_WAIT: st_nxt = ST_POLL;
            ST_DONE: ;
            ST_IDLE: ;
            default: st_nxt = ST_IDLE;
        endcase

        if (RD) begin
            case (ADDR)
                `REG_CMD:    rdata_nxt = {28'h000_0000, op_r};
                `REG_ADDR:   rdata_nxt = {12'h000, addr_r};
                `REG_DATA:   rdata_nxt = {24'h00_0000, data_r};
                `REG_STATUS: rdata_nxt = {16'h0000, 6'h00, err_r,
                                          (st_r == ST_IDLE || st_r == ST_DONE), stat_r};
                `REG_RESULT: rdata_nxt = {24'h00_0000, result_r};
                default:     rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_r     <= ST_IDLE;
            op_r     <= 4'h0;
            addr_r   <= 20'h0_0000;
            data_r   <= 8'h00;
            stat_r   <= 8'h00;
            result_r <= 8'h00;
            err_r    <= 1'b0;
            rdata_r  <= 32'h0000_0000;
        end else begin
            st_r     <= st_nxt;
            op_r     <= op_nxt;
            addr_r   <= addr_nxt;
            data_r   <= data_nxt;
            stat_r   <= stat_nxt;
            result_r <= result_nxt;
            err_r    <= err_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    flash_bus_cycle #(
        .CYCLE (CYCLE)
    ) u_cycle (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .start (cyc_start),
        .req   (cyc_req),
        .addr  (cyc_addr),
        .busy  (cyc_busy),
        .done  (cyc_done),
        .rdata (cyc_rdata),
        .pins  (FLASH_CTRL),
        .dq_o  (DQ_O),
        .dq_oe (DQ_OE),
        .dq_i  (DQ_I)
    );
endmodule

//--- verification/flash_ctl_sva.sv
// port assertions for the flash controller
`include "flash_ctl_regs.svh"
module flash_ctl_sva
    import flash_ctl_pkg::*;
#(
    parameter int CYCLE = `CYCLE_CLKS
) (
    // observed ports
    input wire logic        CLK_SYS,
    input wire logic        RESET,
    input wire logic [7:0]  ADDR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire flash_ctrl_t FLASH_CTRL,
    input wire logic [7:0]  DQ_O,
    input wire logic        DQ_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    int we_low_r;
    int we_low_nxt;
    // cycles the write strobe has been low
    always_comb we_low_nxt = FLASH_CTRL.we_n ? 0 : we_low_r + 1;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) we_low_r <= 0;
        else       we_low_r <= we_low_nxt;
    end
    a_status_mask: assert property (
        $past(RD) && $past(ADDR) == `REG_STATUS |-> !RDATA[0]) else $error("bit 0 not masked");
    a_rdata_quiet: assert property (
        !$past(RD) |-> RDATA == 32'h0000_0000) else $error("read data outside slot");
    a_strobe_excl: assert property (
        !(!FLASH_CTRL.we_n && !FLASH_CTRL.oe_n)) else $error("write and read strobes together");
    a_write_select: assert property (
        !FLASH_CTRL.we_n |-> !FLASH_CTRL.ce_n && DQ_OE) else $error("write without select");
    a_read_release: assert property (
        !FLASH_CTRL.oe_n |-> !DQ_OE && !FLASH_CTRL.ce_n) else $error("bus driven in read");
    a_write_hold: assert property (
        !FLASH_CTRL.we_n && $past(!FLASH_CTRL.we_n) |-> $stable(DQ_O) && $stable(FLASH_CTRL.addr))
        else $error("write data moved");
    a_write_width: assert property (
        $rose(FLASH_CTRL.we_n) |-> we_low_r == CYCLE) else $error("write strobe width");
    a_idle_quiet: assert property (
        FLASH_CTRL.ce_n |-> FLASH_CTRL.we_n && FLASH_CTRL.oe_n) else $error("strobe while idle");
    a_read_hold: assert property (
        !FLASH_CTRL.oe_n && $past(!FLASH_CTRL.oe_n) |-> $stable(FLASH_CTRL.addr))
        else $error("read address moved");
endmodule

bind flash_ctl flash_ctl_sva #(.CYCLE(CYCLE)) sva_inst (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .FLASH_CTRL(FLASH_CTRL), .DQ_O(DQ_O), .DQ_OE(DQ_OE));

//--- verification/flash_model.sv
// behavioural byte-wide flash device facing the controller
module flash_model
    import flash_ctl_pkg::*;
#(
    parameter int BUSY = 6
) (
    // pins and supply knob
    input  wire logic        clk,
    input  wire flash_ctrl_t pins,
    input  wire logic [7:0]  dq_o,
    input  wire logic        supply_low,
    output logic [7:0]       dq_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    logic [7:0] sr, setup, wd, last;
    logic [1:0] mode;
    logic       perm, prev_we, wr2, wkind;
    int         busy;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        sr = 8'h81;
        {setup, wd, last, mode, perm, wkind, busy} = '0;
        prev_we = 1'b1;
    end
    task automatic cmd(input logic [7:0] d, input logic [3:0] a);
        wr2 = setup == 8'h40 || setup == 8'h10;
        if (setup != 8'h00) begin
            if (!wr2 && !(d == 8'hD0 || setup == 8'h60 && (d == 8'h01 || d == 8'hF1)))
                sr[5:4] = 2'b11;
            else if (supply_low) begin
                sr[3] = 1'b1;
                if (wr2 || setup == 8'h60 && d != 8'hD0) sr[4] = 1'b1;
                else sr[5] = 1'b1;
            end
            else if (setup == 8'h60 && perm && d != 8'hF1) begin
                sr[1] = 1'b1;
                if (d == 8'hD0) sr[5] = 1'b1;
                else sr[4] = 1'b1;
            end
            else if (wr2) mem[a] = d;
            else if (d == 8'hF1) perm = 1'b1;
            busy = BUSY;
            wkind = wr2;
            setup = 8'h00;
            mode = 2'd1;
        end else begin
            if (d inside {8'h20, 8'h30, 8'h40, 8'h10, 8'h60}) setup = d;
            if (d == 8'h50) sr[5:1] = {2'b00, 1'b0, sr[2], 1'b0};
            if (d == 8'hB0 && busy > 0) begin
                if (wkind) sr[2] = 1'b1;
                else sr[6] = 1'b1;
                busy = 0;
            end
            if (d == 8'hD0 && (sr[6] || sr[2])) begin
                sr[6] = 1'b0;
                sr[2] = 1'b0;
                busy = BUSY;
            end
            mode = d == 8'hFF ? 2'd0 : d == 8'h90 ? 2'd2 : 2'd1;
        end
    endtask
    // state moves on the falling edge so the controller samples settled data
    always @(negedge clk) begin
        if (busy > 0) busy = busy - 1;
        if (pins.we_n && !prev_we) cmd(wd, pins.addr[3:0]);
        if (!pins.we_n) wd = dq_o;
        if (!pins.oe_n) last = dq_i;
        prev_we = pins.we_n;
    end
    // array, status or identifier read by mode; released bus shows inverse
    always @* begin
        if (!pins.oe_n && !pins.ce_n)
            dq_i = mode == 2'd1 ? {busy == 0, sr[6:0]} : mode == 2'd2 ? {7'h00, perm}
                 : mem[pins.addr[3:0]];
        else dq_i = ~last;
    end
endmodule

//--- verification/tb_flash_ctl.sv
// self-checking bench for the flash controller
`include "flash_ctl_regs.svh"
module tb_flash_ctl;
    import flash_ctl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 0, RESET = 1, WR = 0, RD = 0, low = 0;
    logic [7:0] ADDR = '0, DQ_O, DQ_I;
    logic [31:0] WDATA = '0, RDATA, st;
    logic DQ_OE;
    flash_ctrl_t FLASH_CTRL;
    int bad_count = 0, cmp_count = 0;
    always #2.5 CLK_SYS = ~CLK_SYS;
    flash_ctl #(.CYCLE(2)) flash_ctl_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FLASH_CTRL(FLASH_CTRL),
        .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(DQ_I));
    flash_model flash_model_inst (.clk(CLK_SYS), .pins(FLASH_CTRL), .dq_o(DQ_O),
        .supply_low(low), .dq_i(DQ_I));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK_SYS);
        {RD, ADDR} <= {1'b1, a};
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic op(input logic [3:0] c);
        int n;
        wr(`REG_CMD, {28'h000_0000, c});
        repeat (3) @(posedge CLK_SYS);
        for (n = 0; n < 300; n++) begin
            rd(`REG_STATUS, st);
            if (st[8] === 1'b1) break;
        end
        if (n == 300) chk(st[8], 1'b1);
    endtask
    // status byte fetched by a plain read after 70H, into the result register
    task automatic peek;
        op(`OP_READ_STATUS);
        op(`OP_READ);
        rd(`REG_RESULT, st);
    endtask
    task automatic t_erase;
        wr(`REG_ADDR, 32'h0000_0005);
        op(`OP_BLOCK_ERASE);
        chk(st[7:0], 8'h80);
        $display("t_erase done");
    endtask
    task automatic t_supply;
        low <= 1'b1;
        op(`OP_CHIP_ERASE);
        chk(st[7:0], 8'hA8);
        op(`OP_BYTE_WRITE);
        chk(st[7:0], 8'hB8);
        low <= 1'b0;
        op(`OP_BYTE_WRITE);
        chk(st[7:0], 8'hB8);
        op(`OP_CLEAR_STATUS);
        peek();
        chk(st[7:0] & `SB_RESERVED_MASK, 8'h80);
        $display("t_supply done");
    endtask
    task automatic t_write;
        wr(`REG_ADDR, 32'h0000_0003);
        wr(`REG_DATA, 32'h0000_005A);
        op(`OP_BYTE_WRITE);
        chk(st[7:0], 8'h80);
        op(`OP_READ_ARRAY);
        op(`OP_READ);
        rd(`REG_RESULT, st);
        chk(st[7:0], 8'h5A);
        op(`OP_SUSPEND);
        chk(st[7:0], 8'h80);
        op(`OP_RESUME);
        peek();
        chk(st[7:0] & `SB_RESERVED_MASK, 8'h80);
        $display("t_write done");
    endtask
    task automatic t_lock;
        op(`OP_CLEAR_LOCKS);
        chk(st[7:0], 8'h80);
        op(`OP_LOCK_PERM);
        chk(st[7:0], 8'h80);
        op(`OP_LOCK_BLOCK);
        chk(st[7:0], 8'h92);
        op(`OP_CLEAR_LOCKS);
        chk(st[7:0], 8'hB2);
        op(`OP_READ_ID);
        op(`OP_READ);
        rd(`REG_RESULT, st);
        chk(st[7:0], 8'h01);
        op(`OP_CLEAR_STATUS);
        peek();
        chk(st[7:0] & `SB_RESERVED_MASK, 8'h80);
        $display("t_lock done");
    endtask
    task automatic t_refuse;
        wr(`REG_CMD, 32'h0000_0001);
        wr(`REG_CMD, 32'h0000_0002);
        op(`OP_READ_STATUS);
        chk(st[9], 1'b1);
        wr(`REG_STATUS, 32'h0000_0001);
        rd(`REG_STATUS, st);
        chk(st[9], 1'b0);
        rd(8'h1C, st);
        chk(st, 32'h0000_0000);
        $display("t_refuse done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK_SYS);
        RESET <= 1'b0;
        t_erase();
        t_supply();
        t_write();
        t_lock();
        t_refuse();
        summarize();
    end
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
endmodule
